//--- design/tws_consts.svh
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

// system clock
`define TWS_CLK_HZ        40000000
`define TWS_CLK_NS        25

// bus rates handled by the filters and the output hold
`define TWS_SCL_FS_KHZ    400
`define TWS_SCL_HS_KHZ    2170

// input spike filter, least stable time per mode
`define TWS_FILT_FS_NS    50
`define TWS_FILT_HS_NS    10
`define TWS_FILT_FS_CYC   ((`TWS_FILT_FS_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_FILT_HS_CYC   ((`TWS_FILT_HS_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

// sda output hold after scl falls, least time per mode
`define TWS_HOLD_FS_NS    100
`define TWS_HOLD_HS_NS    25
`define TWS_HOLD_FS_CYC   ((`TWS_HOLD_FS_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)
`define TWS_HOLD_HS_CYC   ((`TWS_HOLD_HS_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

// bus low timeout
`define TWS_TMO_MS        25
`define TWS_TMO_CYC       ((`TWS_TMO_MS * `TWS_CLK_HZ) / 1000)
`define TWS_TMO_W         20

// addressing and commands
`define TWS_ADDR_BASE     7'h48
`define TWS_STRAP_RADIX   3
`define TWS_STRAP_GND     2'h0
`define TWS_STRAP_FLOAT   2'h1
`define TWS_STRAP_SUPPLY  2'h2
`define TWS_STRAP_SETTLE  4'h8
`define TWS_GC_ADDR       8'h00
`define TWS_GC_RESET      8'h06
`define TWS_HS_CODE       5'h01
`define TWS_PTR_POR       8'h00
`define TWS_BYTE_BITS     4'h8

`endif

//--- design/tws_pkg.sv
package tws_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_SKIP
  } tws_state_t;

  typedef enum logic [1:0] {
    KD_ADDR,
    KD_PTR,
    KD_WDATA,
    KD_GCCMD
  } tws_kind_t;

  typedef struct packed {
    tws_state_t st;
    tws_kind_t  kind;
    logic       rw;
    logic       skip_after;
    logic       more;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic       rd_low;
    logic [6:0] my_addr;
    logic       addr_ok;
    logic [3:0] settle;
    logic       scl_p;
    logic       sda_p;
    logic       oe;
    logic       pend;
    logic [3:0] hold;
    logic       hs;
    logic       wr_stb;
    logic [7:0] wr_d;
    logic       gc;
    logic       rd_take;
    logic       conv_en;
  } tws_top_t;

endpackage

//--- design/tws_pin_sync.sv
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_pin_sync #(
  parameter int W  = 2,
  parameter int FW = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // filter mode
  input  wire logic         hs,
  // raw and clean levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);

  localparam logic [FW-1:0] LIM_FS = FW'(`TWS_FILT_FS_CYC);
  localparam logic [FW-1:0] LIM_HS = FW'(`TWS_FILT_HS_CYC);

  typedef struct packed {
    logic [W-1:0]          s1;
    logic [W-1:0]          s2;
    logic [W-1:0]          s3;
    logic [W-1:0]          q;
    logic [W-1:0][FW-1:0]  cnt;
  } tws_sync_t;

  tws_sync_t r;
  tws_sync_t n;

  always_comb begin
    logic [FW-1:0] lim;
    lim = hs ? LIM_HS : LIM_FS;
    n = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // s1 only feeds s2; decisions use s2 and s3
    for (int i = 0; i < W; i++) begin
      if ((r.s2[i] == r.s3[i]) && (r.s3[i] != r.q[i])) begin
        if (r.cnt[i] + FW'(1) >= lim) begin
          n.q[i]   = r.s3[i];
          n.cnt[i] = '0;
        end else begin
          n.cnt[i] = r.cnt[i] + FW'(1);
        end
      end else begin
        n.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r <= '{s1: '1, s2: '1, s3: '1, q: '1, cnt: '0};
    end else begin
      r <= n;
    end
  end

  assign q = r.q;

endmodule

//--- design/tws_low_timer.sv
`timescale 1ns/1ps

module tws_low_timer #(
  parameter int W   = 20,
  parameter int CYC = 1000000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // watched line
  input  wire logic armed,
  input  wire logic line_low,
  output logic      expired
);

  localparam logic [W-1:0] LAST = W'(CYC - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         fired;
    logic         exp;
  } tws_tmr_t;

  tws_tmr_t r;
  tws_tmr_t n;

  always_comb begin
    n = r;
    n.exp = 1'b0;
    if (!armed || !line_low) begin
      n.cnt   = '0;
      n.fired = 1'b0;
    end else if (!r.fired) begin
      if (r.cnt == LAST) begin
        n.exp   = 1'b1;
        n.fired = 1'b1;
      end else begin
        n.cnt = r.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r <= '{cnt: '0, fired: 1'b0, exp: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign expired = r.exp;

endmodule

//--- design/tws_slave.sv
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_slave #(
  parameter int TMO_CYC = `TWS_TMO_CYC,
  parameter int TMO_W   = `TWS_TMO_W
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // address straps, 0 ground, 1 floating, 2 supply
  input  wire logic [1:0] addr_strap_low,
  input  wire logic [1:0] addr_strap_high,
  // register file side
  output logic [7:0]      reg_ptr,
  output logic            rd_low_byte,
  input  wire logic [7:0] rd_data,
  output logic            rd_take,
  output logic            wr_strobe,
  output logic [7:0]      wr_data,
  output logic            gc_reset,
  // mode and conversion control
  output logic            hs_mode,
  input  wire logic       power_down_request_bit,
  input  wire logic       conv_busy,
  output logic            conv_enable,
  output logic            conv_abort
);
  import tws_pkg::*;

  localparam tws_top_t TOP_RST = '{
    st: ST_IDLE, kind: KD_ADDR, scl_p: 1'b1, sda_p: 1'b1,
    conv_en: 1'b1, ptr: `TWS_PTR_POR, default: '0};
  localparam logic [3:0] HOLD_FS = 4'(`TWS_HOLD_FS_CYC);
  localparam logic [3:0] HOLD_HS = 4'(`TWS_HOLD_HS_CYC);

  tws_top_t   r;
  tws_top_t   n;
  logic [1:0] bus_f;
  logic [3:0] strap_f;
  logic [1:0] tmo;
  logic       scl_f;
  logic       sda_f;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic [6:0] strap_addr;

  tws_pin_sync #(.W(2)) u_bus_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .hs      (r.hs),
    .pin     ({scl_in, sda_in}),
    .q       (bus_f)
  );

  tws_pin_sync #(.W(4)) u_strap_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .hs      (1'b0),
    .pin     ({addr_strap_high, addr_strap_low}),
    .q       (strap_f)
  );

  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];

  // one watchdog per line, armed between start and stop
  for (genvar g = 0; g < 2; g++) begin : g_tmo
    tws_low_timer #(.W(TMO_W), .CYC(TMO_CYC)) u_tmr (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .armed    (r.st != ST_IDLE),
      .line_low (~bus_f[g]),
      .expired  (tmo[g])
    );
  end

  assign scl_rise = scl_f && !r.scl_p;
  assign scl_fall = !scl_f && r.scl_p;
  // sda edge with scl steady high is control, never data
  assign start = scl_f && r.scl_p && r.sda_p && !sda_f;
  assign stop  = scl_f && r.scl_p && !r.sda_p && sda_f;

  function automatic logic [1:0] strap_lvl(input logic [1:0] c);
    if (c == `TWS_STRAP_GND) begin
      strap_lvl = 2'h0;
    end else if (c == `TWS_STRAP_FLOAT) begin
      strap_lvl = 2'h1;
    end else begin
      strap_lvl = 2'h2;
    end
  endfunction

  assign strap_addr = `TWS_ADDR_BASE
                    + 7'(`TWS_STRAP_RADIX * strap_lvl(strap_f[3:2]))
                    + 7'(strap_lvl(strap_f[1:0]));

  always_comb begin
    n = r;
    n.wr_stb  = 1'b0;
    n.gc      = 1'b0;
    n.rd_take = 1'b0;
    n.scl_p   = scl_f;
    n.sda_p   = sda_f;
    // sample straps once the synchronisers have settled
    if (!r.addr_ok) begin
      if (r.settle == `TWS_STRAP_SETTLE) begin
        n.addr_ok = 1'b1;
        n.my_addr = strap_addr;
      end else begin
        n.settle = r.settle + 4'h1;
      end
    end
    // sda pull changes after hold time past scl fall; start, stop and timeout release it at once
    if (r.hold != 4'h0) begin
      n.hold = r.hold - 4'h1;
      if (r.hold == 4'h1) begin
        n.oe = r.pend;
      end
    end
    // finish the running conversion before powering down
    n.conv_en = !power_down_request_bit || (r.conv_en && conv_busy);
    if (r.gc) begin
      n.conv_en = 1'b1;
    end
    if (!r.addr_ok) begin
      n.st = ST_IDLE;
    end else if (tmo != 2'b00) begin
      n.st   = ST_IDLE;
      n.oe   = 1'b0;
      n.pend = 1'b0;
      n.hold = 4'h0;
      n.hs   = 1'b0;
    end else if (start) begin
      // repeated start keeps high-speed mode
      n.st     = ST_RX;
      n.kind   = KD_ADDR;
      n.cnt    = 4'h0;
      n.oe     = 1'b0;
      n.pend   = 1'b0;
      n.hold   = 4'h0;
      n.rd_low = 1'b0;
    end else if (stop) begin
      n.st   = ST_IDLE;
      n.hs   = 1'b0;
      n.oe   = 1'b0;
      n.pend = 1'b0;
      n.hold = 4'h0;
    end else if (scl_rise) begin
      unique case (r.st)
        ST_RX: begin
          n.sh  = {r.sh[6:0], sda_f};
          n.cnt = r.cnt + 4'h1;
        end
        ST_TX: begin
          n.cnt = r.cnt + 4'h1;
        end
        ST_TX_ACK: begin
          n.more = !sda_f;
          if (!sda_f) begin
            n.rd_low = 1'b1;
          end
        end
        ST_IDLE, ST_RX_ACK, ST_SKIP: begin
        end
      endcase
    end else if (scl_fall) begin
      n.hold = r.hs ? HOLD_HS : HOLD_FS;
      unique case (r.st)
        ST_RX: begin
          if (r.cnt == `TWS_BYTE_BITS) begin
            n.cnt        = 4'h0;
            n.st         = ST_RX_ACK;
            n.pend       = 1'b1;
            n.skip_after = 1'b0;
            unique case (r.kind)
              KD_ADDR: begin
                if (r.sh[7:1] == r.my_addr) begin
                  n.rw   = r.sh[0];
                  n.kind = KD_PTR;
                end else if (r.sh == `TWS_GC_ADDR) begin
                  n.rw   = 1'b0;
                  n.kind = KD_GCCMD;
                end else begin
                  n.pend = 1'b0;
                  n.st   = ST_SKIP;
                  if (r.sh[7:3] == `TWS_HS_CODE) begin
                    n.hs = 1'b1;
                  end
                end
              end
              KD_PTR: begin
                n.ptr  = r.sh;
                n.kind = KD_WDATA;
              end
              KD_WDATA: begin
                n.wr_stb = 1'b1;
                n.wr_d   = r.sh;
              end
              KD_GCCMD: begin
                n.skip_after = 1'b1;
                if (r.sh == `TWS_GC_RESET) begin
                  n.gc  = 1'b1;
                  n.ptr = `TWS_PTR_POR;
                end
              end
            endcase
          end
        end
        ST_RX_ACK: begin
          n.cnt  = 4'h0;
          n.pend = 1'b0;
          if (r.skip_after) begin
            n.st = ST_SKIP;
          end else if (r.rw) begin
            n.st      = ST_TX;
            n.sh      = rd_data;
            n.pend    = !rd_data[7];
            n.rd_take = 1'b1;
          end else begin
            n.st = ST_RX;
          end
        end
        ST_TX: begin
          if (r.cnt == `TWS_BYTE_BITS) begin
            n.st   = ST_TX_ACK;
            n.pend = 1'b0;
          end else begin
            n.sh   = {r.sh[6:0], 1'b0};
            n.pend = !r.sh[6];
          end
        end
        ST_TX_ACK: begin
          n.pend = 1'b0;
          if (r.more) begin
            n.st      = ST_TX;
            n.cnt     = 4'h0;
            n.sh      = rd_data;
            n.pend    = !rd_data[7];
            n.rd_take = 1'b1;
          end else begin
            n.st = ST_SKIP;
          end
        end
        ST_IDLE, ST_SKIP: begin
          n.pend = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r <= TOP_RST;
    end else begin
      r <= n;
    end
  end

  // open drain: only ever pulls low, scl never driven
  assign sda_out     = 1'b0;
  assign sda_oe      = r.oe;
  assign reg_ptr     = r.ptr;
  assign rd_low_byte = r.rd_low;
  assign rd_take     = r.rd_take;
  assign wr_strobe   = r.wr_stb;
  assign wr_data     = r.wr_d;
  assign gc_reset    = r.gc;
  assign hs_mode     = r.hs;
  assign conv_enable = r.conv_en;
  assign conv_abort  = r.gc;

endmodule

//--- bench/tws_slave_monitor.sv
`timescale 1ns/1ps

module tws_slave_monitor #(
  parameter int TMO_CYC = 200,
  parameter int TMO_W   = 20
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       nrst,
  // bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // straps
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  // register file side
  input wire logic [7:0] reg_ptr,
  input wire logic       rd_low_byte,
  input wire logic [7:0] rd_data,
  input wire logic       rd_take,
  input wire logic       wr_strobe,
  input wire logic [7:0] wr_data,
  input wire logic       gc_reset,
  // mode and conversion
  input wire logic       hs_mode,
  input wire logic       power_down_request_bit,
  input wire logic       conv_busy,
  input wire logic       conv_enable,
  input wire logic       conv_abort
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // margin covers the input synchroniser and filter
  logic [TMO_W:0] low_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst || scl_in)
      low_r <= '0;
    else if (low_r != '1)
      low_r <= low_r + 1'b1;
  end

  sequence s_gc_restart;
    gc_reset ##1 conv_enable;
  endsequence

  a_wr_pulse_single: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  a_gc_abort_pair: assert property (gc_reset |-> conv_abort)
    else $error("abort missing with general call reset");
  a_gc_ptr_home: assert property (gc_reset |-> ##[0:1] reg_ptr == 8'h00)
    else $error("pointer not cleared by general call");
  a_gc_conv_run: assert property (gc_reset |-> s_gc_restart)
    else $error("conversion not restarted after general call");
  a_pd_run: assert property (!power_down_request_bit |=> conv_enable)
    else $error("conversions stopped without power down");
  a_pd_stop: assert property (power_down_request_bit && !conv_busy &&
    !gc_reset |=> !conv_enable)
    else $error("conversions kept after power down");
  a_rd_ptr_hold: assert property (rd_take |-> $stable(reg_ptr))
    else $error("pointer moved during a read");
  a_never_high: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_tmo_release: assert property (int'(low_r) >= TMO_CYC + 16 |->
    !sda_oe && !hs_mode)
    else $error("port still busy after bus timeout");
  // the pull may only move while the clock pin is low
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data pin pull changed while clock high");
  // master code byte must stay unacknowledged for eight cycles after hs_mode rises
  a_hs_no_ack: assert property ($rose(hs_mode) |=> (!sda_oe) [*8])
    else $error("high-speed master code was acknowledged");
endmodule

bind tws_slave tws_slave_monitor #(.TMO_CYC(TMO_CYC), .TMO_W(TMO_W))
  u_tws_slave_monitor (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_strap_low(addr_strap_low), .addr_strap_high(addr_strap_high),
  .reg_ptr(reg_ptr), .rd_low_byte(rd_low_byte), .rd_data(rd_data),
  .rd_take(rd_take), .wr_strobe(wr_strobe), .wr_data(wr_data),
  .gc_reset(gc_reset), .hs_mode(hs_mode),
  .power_down_request_bit(power_down_request_bit),
  .conv_busy(conv_busy), .conv_enable(conv_enable),
  .conv_abort(conv_abort));

//--- bench/tws_master.sv
`timescale 1ns/1ps

module tws_master (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda_line,
  output logic      scl_o,
  output logic      sda_o
);
  // half bit in cycles: 50 gives 400 kHz, 10 gives 2 MHz
  int h = 50;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic start();
    sda_o = 1'b1;
    tick(h);
    scl_o = 1'b1;
    tick(h);
    sda_o = 1'b0;
    tick(h);
    scl_o = 1'b0;
    tick(h);
  endtask

  task automatic stop();
    sda_o = 1'b0;
    tick(h);
    scl_o = 1'b1;
    tick(h);
    sda_o = 1'b1;
    tick(h);
  endtask

  // data moves only while scl is low
  task automatic xfer_bit(input logic b, output logic r);
    sda_o = b;
    tick(h);
    scl_o = 1'b1;
    tick(h / 2);
    r = sda_line;
    tick(h - h / 2);
    scl_o = 1'b0;
    tick(2);
  endtask

  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r[i]);
    xfer_bit(ack_in, ack);
  endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps

module tb;
  logic        sys_clk;
  logic        nrst = 1'b0;
  logic [1:0]  strap_l = 2'h0;
  logic [1:0]  strap_h = 2'h0;
  logic [7:0]  rd_data = 8'h00;
  logic        pd = 1'b0;
  logic        busy = 1'b0;
  wire         scl;
  wire         sda_m;
  wire         sda_out;
  wire         sda_oe;
  wire         sda_line = sda_m & !sda_oe;
  wire  [7:0]  reg_ptr;
  wire  [7:0]  wr_data;
  wire         rd_low_byte;
  wire         rd_take;
  wire         wr_strobe;
  wire         gc_reset;
  wire         hs_mode;
  wire         conv_enable;
  wire         conv_abort;
  integer      fails = 0;
  integer      checks = 0;
  integer      takes = 0;
  integer      seed = 69040;
  logic [7:0]  mem [256];
  logic [15:0] got_q[$];
  logic        gc_seen = 1'b0;
  logic [6:0]  my;
  logic [7:0]  p;
  logic [7:0]  q;
  logic [7:0]  d0;
  logic [7:0]  d1;

  // timeout must exceed the longest legal low run of a frame
  tws_slave #(.TMO_CYC(4000), .TMO_W(20)) u_tws_slave (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(strap_l),
    .addr_strap_high(strap_h), .reg_ptr(reg_ptr),
    .rd_low_byte(rd_low_byte), .rd_data(rd_data), .rd_take(rd_take),
    .wr_strobe(wr_strobe), .wr_data(wr_data), .gc_reset(gc_reset),
    .hs_mode(hs_mode), .power_down_request_bit(pd), .conv_busy(busy),
    .conv_enable(conv_enable), .conv_abort(conv_abort));

  tws_master u_tws_master (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl_o(scl), .sda_o(sda_m));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // register file model: low byte is the inverse of the high byte
  always @(negedge sys_clk) begin
    rd_data <= rd_low_byte ? ~mem[reg_ptr] : mem[reg_ptr];
    busy <= 1'($random(seed));
    pd <= (($random(seed) & 7) == 0);
  end

  // pulses are looked at mid-cycle, where they are settled
  always @(negedge sys_clk) begin
    if (wr_strobe === 1'b1)
      got_q.push_back({reg_ptr, wr_data});
    if (gc_reset === 1'b1)
      gc_seen <= 1'b1;
    if (rd_take === 1'b1)
      takes++;
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] d, input logic exp_ack,
                      input string nm);
    logic [7:0] r;
    logic       a;
    u_tws_master.xfer_byte(d, 1'b1, r, a);
    chk(nm, {15'h0, exp_ack}, {15'h0, !a});
  endtask

  task automatic recv(input logic nack, input logic [7:0] exp,
                      input string nm);
    logic [7:0] r;
    logic       a;
    u_tws_master.xfer_byte(8'hFF, nack, r, a);
    chk(nm, {8'h00, exp}, {8'h00, r});
  endtask

  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(25 * 90000);
    fails++;
    give_verdict();
  end

  initial begin
    foreach (mem[i])
      mem[i] = 8'($random(seed));
    for (int k = 0; k < 9; k++) begin
      strap_h = 2'(k / 3);
      strap_l = 2'(k % 3);
      nrst = 1'b0;
      repeat (6) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (20) @(negedge sys_clk);
      chk("ptr_reset", 16'h0000, {8'h00, reg_ptr});
      // straps now carry noise; the latched address must hold
      strap_l = 2'($random(seed));
      strap_h = 2'($random(seed));
      my = 7'h48 + 7'(k);
      u_tws_master.start();
      send({my, 1'b0}, 1'b1, "strap_addr");
      u_tws_master.stop();
    end
    {p, d0, d1, q} = 32'($random(seed));
    u_tws_master.start();
    send({my, 1'b0}, 1'b1, "addr_w");
    send(p, 1'b1, "ptr");
    send(d0, 1'b1, "data0");
    send(d1, 1'b1, "data1");
    u_tws_master.stop();
    chk("wr_count", 16'd2, 16'(got_q.size()));
    if (got_q.size() == 2) begin
      chk("wr0", {p, d0}, got_q[0]);
      chk("wr1", {p, d1}, got_q[1]);
    end
    u_tws_master.start();
    send({my, 1'b0}, 1'b1, "addr_w2");
    send(q, 1'b1, "ptr_only");
    u_tws_master.start();
    send({my, 1'b1}, 1'b1, "addr_r");
    recv(1'b0, mem[q], "rd_msb");
    recv(1'b1, ~mem[q], "rd_lsb");
    u_tws_master.stop();
    chk("ptr_only_count", 16'd2, 16'(got_q.size()));
    u_tws_master.start();
    send({my, 1'b1}, 1'b1, "addr_r2");
    recv(1'b1, mem[q], "rd_again");
    u_tws_master.start();
    send({my ^ 7'h01, 1'b1}, 1'b0, "addr_other");
    u_tws_master.stop();
    u_tws_master.start();
    send({5'h01, 3'($random(seed))}, 1'b0, "hs_code");
    chk("hs_on", 16'h0001, {15'h0, hs_mode});
    u_tws_master.h = 10;
    u_tws_master.start();
    send({my, 1'b1}, 1'b1, "addr_hs");
    recv(1'b1, mem[q], "rd_hs");
    u_tws_master.stop();
    chk("hs_off", 16'h0000, {15'h0, hs_mode});
    u_tws_master.h = 50;
    for (int g = 0; g < 2; g++) begin
      u_tws_master.start();
      send(8'h00, 1'b1, "gc_addr");
      send(8'h05 + 8'(g), 1'b1, "gc_cmd");
      u_tws_master.stop();
      chk("gc_seen", {15'h0, 1'(g)}, {15'h0, gc_seen});
    end
    chk("gc_ptr", 16'h0000, {8'h00, reg_ptr});
    mem[0] = mem[0] & 8'h7F;
    u_tws_master.start();
    send({my, 1'b1}, 1'b1, "addr_tmo");
    u_tws_master.tick(10);
    chk("drive_low", 16'h0001, {15'h0, sda_oe});
    u_tws_master.tick(4100);
    chk("tmo_free", 16'h0000, {15'h0, sda_oe});
    u_tws_master.start();
    send({my, 1'b0}, 1'b1, "addr_after");
    u_tws_master.stop();
    // five read bytes were loaded: msb, lsb, again, high speed, timeout
    chk("take_count", 16'd5, 16'(takes));
    give_verdict();
  end
endmodule
